// ---- rtl/ccr_cfg_mem.v ----
// configuration memory image scanned by the signature engine
// assumes one write port from test or load logic and one reader
`default_nettype none

module ccr_cfg_mem #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire ref_clk,
  input wire ce,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  input wire rd_en,
  input wire [AW-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data_q
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // no reset on the array: it stands for configuration storage
  always @(posedge ref_clk) begin
    if (ce) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      if (rd_en) begin
        rd_data_q <= mem[rd_addr];
      end
    end
  end

endmodule // ccr_cfg_mem

`default_nettype wire

// ---- rtl/ccr_defs.vh ----
// constants shared by the configuration signature readout block
// assumes the includer runs on ref_clk at 250 MHz
`ifndef CCR_DEFS_VH
`define CCR_DEFS_VH

// reference clock and internal check oscillator rates, in MHz
`define CCR_REF_MHZ 8'd250
`define CCR_OSC_MHZ 8'd80

// signature width and generator polynomial
`define CCR_SIG_W 32
`define CCR_POLY 32'h04c11db7
`define CCR_SEED 32'hffffffff

// reset values
`define CCR_RST_SIG 32'h00000000
`define CCR_RST_BIT 1'b0

// default divisor applied to the check oscillator
`define CCR_DEF_DIV 8

// readout shift register: msb leaves first
`define CCR_MSB 31

`endif

// ---- rtl/ccr_readout.v ----
// configuration signature engine, error flag and serial readout cell
// assumes readout_clk, shift_nload and load_src come from pins or user
// logic in another domain; memory writes and precomputed value are local
//
// Function
// - computed 32-bit signature readable by user logic
// - loads and shifts only on readout clock rise
// - shift_nload high shifts one bit per rise
// - load_src 0 loads precomputed value
// - load_src 1 loads computed signature
// - load_src ignored while shifting
// - error flag timed by internal oscillator
// - error flag high when signature mismatches
// - registered serial bit, 31 clocks read 32
// - check clocked by oscillator over divisor
`include "ccr_defs.vh"
`default_nettype none

module ccr_readout #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW = 4,
  parameter CHECK_DIV = `CCR_DEF_DIV
) (
  input wire ref_clk,
  input wire resetn,
  input wire ce,
  input wire readout_clk,
  input wire shift_nload,
  input wire load_src,
  input wire [`CCR_SIG_W-1:0] precomp_crc,
  input wire cfg_wr_en,
  input wire [AW-1:0] cfg_wr_addr,
  input wire [WIDTH-1:0] cfg_wr_data,
  output reg regout_q,
  output reg crc_error_q
);

  localparam S_WAIT = 3'b001;
  localparam S_FETCH = 3'b010;
  localparam S_FOLD = 3'b100;

  // terminal counts, cut on purpose to the widths of the counters they meet
  localparam [31:0] DIV_LAST_W = CHECK_DIV - 1;
  localparam [31:0] ADDR_LAST_W = DEPTH - 1;
  wire [15:0] div_last = DIV_LAST_W[15:0];
  wire [AW-1:0] addr_last = ADDR_LAST_W[AW-1:0];

  // one data word folded into the running signature, msb first
  // no reflection and no final inversion: compared with precomp_crc as is
  function [`CCR_SIG_W-1:0] crc_fold;
    input [`CCR_SIG_W-1:0] crc;
    input [WIDTH-1:0] data;
    integer i;
    reg [`CCR_SIG_W-1:0] c;
    begin
      c = crc;
      for (i = WIDTH - 1; i >= 0; i = i - 1) begin
        if (c[`CCR_MSB] ^ data[i]) begin
          c = {c[`CCR_MSB-1:0], 1'b0} ^ `CCR_POLY;
        end else begin
          c = {c[`CCR_MSB-1:0], 1'b0};
        end
      end
      crc_fold = c;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // internal oscillator model: fractional accumulator off ref_clk

  reg [7:0] osc_acc_q;
  reg osc_tick_q;
  wire [8:0] osc_sum = {1'b0, osc_acc_q} + {1'b0, `CCR_OSC_MHZ};
  reg [15:0] div_cnt_q;
  reg check_en_q;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      osc_acc_q <= 8'h00;
      osc_tick_q <= 1'b0;
      div_cnt_q <= 16'h0000;
      check_en_q <= 1'b0;
    end else if (ce) begin
      // tick rate is 80/250 of ref_clk on average, jitter of one cycle
      if (osc_sum >= {1'b0, `CCR_REF_MHZ}) begin
        osc_acc_q <= osc_sum[7:0] - `CCR_REF_MHZ;
        osc_tick_q <= 1'b1;
      end else begin
        osc_acc_q <= osc_sum[7:0];
        osc_tick_q <= 1'b0;
      end
      check_en_q <= 1'b0;
      if (osc_tick_q) begin
        if (div_cnt_q == div_last) begin
          div_cnt_q <= 16'h0000;
          check_en_q <= 1'b1;
        end else begin
          div_cnt_q <= div_cnt_q + 16'h0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // signature engine: one memory word per divided oscillator step

  reg [2:0] state_q;
  reg [AW-1:0] addr_q;
  reg [`CCR_SIG_W-1:0] crc_q;
  reg [`CCR_SIG_W-1:0] sig_q;
  wire [WIDTH-1:0] mem_data;
  wire [`CCR_SIG_W-1:0] crc_d = crc_fold(crc_q, mem_data);
  wire last_word = (addr_q == addr_last);

  // the image freezes with ce like every other register of the block
  ccr_cfg_mem #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .ref_clk(ref_clk),
    .ce(ce),
    .wr_en(cfg_wr_en),
    .wr_addr(cfg_wr_addr),
    .wr_data(cfg_wr_data),
    .rd_en(state_q == S_FETCH),
    .rd_addr(addr_q),
    .rd_data_q(mem_data)
  );

  // a step takes three ref_clk: check_en pulses closer than that are dropped,
  // so the oscillator over its divisor must stay below a third of ref_clk

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= S_WAIT;
      addr_q <= {AW{1'b0}};
      crc_q <= `CCR_SEED;
      sig_q <= `CCR_RST_SIG;
      crc_error_q <= `CCR_RST_BIT;
    end else if (ce) begin
      case (state_q)
        S_WAIT: begin
          if (check_en_q) begin
            state_q <= S_FETCH;
          end
        end
        S_FETCH: begin
          state_q <= S_FOLD;
        end
        S_FOLD: begin
          state_q <= S_WAIT;
          if (last_word) begin
            addr_q <= {AW{1'b0}};
            crc_q <= `CCR_SEED;
            sig_q <= crc_d;
            // flag follows each finished pass, so a repaired image clears it
            crc_error_q <= (crc_d != precomp_crc);
          end else begin
            addr_q <= addr_q + {{(AW-1){1'b0}}, 1'b1};
            crc_q <= crc_d;
          end
        end
        default: begin
          state_q <= S_WAIT;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // readout cell: pin inputs synchronised, acts on readout clock rise

  reg [2:0] rclk_q;
  reg [2:0] snl_q;
  reg [2:0] lsrc_q;
  reg [`CCR_SIG_W-1:0] shreg_q;
  reg [`CCR_SIG_W-1:0] load_val;
  wire rclk_rise = rclk_q[1] & ~rclk_q[2];

  // source for a parallel load; not looked at on the shift path
  always @* begin
    if (lsrc_q[2]) begin
      load_val = sig_q;
    end else begin
      load_val = precomp_crc;
    end
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rclk_q <= 3'h0;
      snl_q <= 3'h7;
      lsrc_q <= 3'h0;
      shreg_q <= `CCR_RST_SIG;
      regout_q <= `CCR_RST_BIT;
    end else if (ce) begin
      // ce low holds the synchronisers too, so a pin edge that comes and goes
      // while frozen is lost rather than replayed later
      // third stage holds the control level from just before the edge
      rclk_q <= {rclk_q[1:0], readout_clk};
      snl_q <= {snl_q[1:0], shift_nload};
      lsrc_q <= {lsrc_q[1:0], load_src};
      if (rclk_rise) begin
        if (snl_q[2]) begin
          // load_src not looked at on this path
          shreg_q <= {shreg_q[`CCR_MSB-1:0], 1'b0};
          regout_q <= shreg_q[`CCR_MSB-1];
        end else begin
          // each low edge reloads; holding low two edges is harmless
          shreg_q <= load_val;
          regout_q <= load_val[`CCR_MSB];
        end
      end
    end
  end

endmodule // ccr_readout

`default_nettype wire

// ---- tb/ccr_chk_checker.sv ----
// checker on the readout cell ports
// assumes one ref_clk domain; bound below
`default_nettype none
module ccr_chk #(parameter int CHECK_DIV = 8) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic readout_clk,
  input wire logic shift_nload,
  input wire logic load_src,
  input wire logic [31:0] precomp_crc,
  input wire logic cfg_wr_en,
  input wire logic regout_q,
  input wire logic crc_error_q
);
  timeunit 1ns;
  timeprecision 100ps;
  // two passes of the check loop, with slack for oscillator jitter
  localparam int QUIET = 128 * CHECK_DIV + 200;
  logic [5:0] shifts_q;
  logic [11:0] quiet_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      shifts_q <= 6'h0;
      quiet_q <= 12'h0;
    end else begin
      if ($rose(readout_clk))
        shifts_q <= shift_nload ? shifts_q + {5'h0, shifts_q != 6'h3f} : 6'h0;
      quiet_q <= (cfg_wr_en || $changed(precomp_crc)) ? 12'h0 : quiet_q + {11'h0, ~&quiet_q};
    end
  end
  ////////////////////////////////////////
  rise_only_a: assert property ($changed(regout_q) |-> $past(readout_clk))
    else $error("bit moved off a rise");
  low_hold_a: assert property (!readout_clk [*4] |-> $stable(regout_q))
    else $error("bit moved while clock low");
  one_bit_a: assert property ($changed(regout_q) |=> $stable(regout_q) [*4])
    else $error("two bits for one rise");
  load_pre_a: assert property (
    $rose(readout_clk) && !shift_nload && !load_src |-> ##3 regout_q == precomp_crc[31])
    else $error("load missed precomputed msb");
  tail_zero_a: assert property (
    $rose(readout_clk) && shift_nload && shifts_q >= 6'd31 |-> ##3 !regout_q)
    else $error("no zero after 32 bits");
  flag_pace_a: assert property ($changed(crc_error_q) |=> $stable(crc_error_q) [*8])
    else $error("flag faster than check pace");
  flag_cause_a: assert property ($changed(crc_error_q) |-> quiet_q < QUIET)
    else $error("flag moved without cause");
  reset_clear_a: assert property ($rose(resetn) |-> !regout_q && !crc_error_q)
    else $error("outputs not clear after reset");
endmodule // ccr_chk
bind ccr_readout ccr_chk #(.CHECK_DIV(CHECK_DIV)) u_chk (.ref_clk, .resetn, .readout_clk,
  .shift_nload, .load_src, .precomp_crc, .cfg_wr_en, .regout_q, .crc_error_q);
`default_nettype wire

// ---- tb/ccr_readout_bench.sv ----
// bench for the signature readout cell
// assumes ccr_user drives the readout side
`default_nettype none
module ccr_readout_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic resetn, cfg_wr_en, ce;
  logic [3:0] cfg_wr_addr;
  logic [31:0] cfg_wr_data, precomp_crc;
  logic [31:0] img [16];
  wire logic readout_clk, shift_nload, load_src, regout_q, crc_error_q;
  int num_errors = 0;
  int checks_done = 0;
  always #2 ref_clk = ~ref_clk;
  ccr_user u_user (.ref_clk, .readout_clk, .shift_nload, .load_src);
  ccr_readout #(.CHECK_DIV(1)) DUT (.ref_clk, .resetn, .ce, .readout_clk,
    .shift_nload, .load_src, .precomp_crc, .cfg_wr_en, .cfg_wr_addr, .cfg_wr_data,
    .regout_q, .crc_error_q);
  ////////////////////////////////////////
  task automatic print_verdict();
    if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [31:0] crc_of(input logic [31:0] flip);
    logic [31:0] c = 32'hffffffff;
    logic [31:0] w;
    for (int a = 0; a < 16; a++) begin
      w = img[a] ^ (a == 5 ? flip : 32'h0);
      for (int b = 31; b >= 0; b--)
        c = {c[30:0], 1'b0} ^ ((c[31] ^ w[b]) ? 32'h04c11db7 : 32'h0);
    end
    return c;
  endfunction
  // flip xors into word 5 only as it is written; the img array itself stays clean
  task automatic fill(input logic [31:0] flip);
    for (int a = 0; a < 16; a++) begin
      cfg_wr_en = 1'b1;
      cfg_wr_addr = a[3:0];
      cfg_wr_data = img[a] ^ (a == 5 ? flip : 32'h0);
      @(posedge ref_clk);
      #1;
    end
    cfg_wr_en = 1'b0;
  endtask
  // soft errors are judged from the flag, not the shifted signature
  task automatic wait_flag(input logic e);
    repeat (600) if (crc_error_q !== e) begin
      @(posedge ref_clk);
      #1;
    end
    check("error flag", {31'h0, crc_error_q}, {31'h0, e});
  endtask
  task automatic read_out(input logic [31:0] exp, input logic src);
    u_user.load(src);
    u_user.load_src = !src;
    check("first bit", {31'h0, regout_q}, {31'h0, exp[31]});
    for (int k = 30; k >= 0; k--) begin
      u_user.pulse();
      check("shifted bit", {31'h0, regout_q}, {31'h0, exp[k]});
    end
    u_user.pulse();
    check("drained bit", {31'h0, regout_q}, 32'h0);
  endtask
  // a readout edge given while ce is low must leave the bit where it was
  task automatic freeze_hold();
    u_user.load(1'b0);
    ce = 1'b0;
    u_user.pulse();
    ce = 1'b1;
    check("frozen bit", {31'h0, regout_q}, {31'h0, precomp_crc[31]});
    u_user.pulse();
    check("thawed bit", {31'h0, regout_q}, {31'h0, precomp_crc[30]});
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    print_verdict();
  end
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    cfg_wr_en = 1'b0;
    cfg_wr_addr = 4'h0;
    cfg_wr_data = 32'h0;
    precomp_crc = 32'h6b2df0c4;
    for (int a = 0; a < 16; a++) img[a] = 32'h9e3779b9 * (a + 1);
    repeat (6) @(posedge ref_clk);
    #1 resetn = 1'b1;
    fill(32'h0);
    read_out(precomp_crc, 1'b0);
    freeze_hold();
    read_out(crc_of(32'h0), 1'b1);
    precomp_crc = crc_of(32'h0);
    wait_flag(1'b0);
    fill(32'h00000100);
    wait_flag(1'b1);
    // read while faulted, so signature and precomputed value differ
    read_out(crc_of(32'h00000100), 1'b1);
    // outside recovery: the image is rewritten clean, as a reconfiguration would
    fill(32'h0);
    wait_flag(1'b0);
    print_verdict();
  end
endmodule // ccr_readout_bench
`default_nettype wire

// ---- tb/ccr_user.sv ----
// user logic in front of the readout cell
// assumes callers run just after a ref_clk rise
`default_nettype none
module ccr_user (
  input wire logic ref_clk,
  output logic readout_clk,
  output logic shift_nload,
  output logic load_src
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    readout_clk = 1'b0;
    shift_nload = 1'b1;
    load_src = 1'b0;
  end
  // 4 cycles high and low: the pin crosses a 2-flop synchroniser
  task automatic pulse();
    repeat (4) @(posedge ref_clk);
    #1 readout_clk = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 readout_clk = 1'b0;
  endtask
  task automatic load(input logic src);
    shift_nload = 1'b0;
    load_src = src;
    pulse();
    pulse();
    shift_nload = 1'b1;
  endtask
endmodule // ccr_user
`default_nettype wire
